/* src/mcuid_pkg.sv */
// Purpose: Shared constants, types and the data path function of the instruction core.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file index, 8-deep return stack.
// Notes: The widths, opcodes, addresses and reset values used by the core live here.
`default_nettype none

package mcuid_pkg;

    // ==========================================================================
    // Widths and sequencing
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int SP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int RB_ADDR_W = 2;
    localparam int RB_DATA_W = 16;

    typedef enum logic [1:0] {ph_fetch, ph_read, ph_exec, ph_adv} mcuid_phase_t;

    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
    localparam logic [PC_W-1:0] PC_SKIP = 13'h0002;
    localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

    // ==========================================================================
    // Opcode fields
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_FLOW = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;

    localparam logic [3:0] OP_MOVE_ACC_TO_REG = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSKP = 4'hB;
    localparam logic [3:0] OP_RRC = 4'hC;
    localparam logic [3:0] OP_RLC = 4'hD;
    localparam logic [3:0] OP_SWAP = 4'hE;
    localparam logic [3:0] OP_INCSKP = 4'hF;

    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_TSC = 2'h2;
    localparam logic [1:0] BIT_TSS = 2'h3;

    localparam logic [7:0] CTL_RETURN = 8'h08;
    localparam logic [7:0] CTL_IEXIT = 8'h09;
    localparam logic [7:0] CTL_KICK = 8'h64;
    localparam logic [7:0] CTL_STANDBY = 8'h63;

    localparam logic [3:0] LIT_OR = 4'h8;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [3:0] LIT_XOR = 4'hA;
    localparam logic [1:0] LIT_MOV_P = 2'h0;
    localparam logic [1:0] LIT_RET_P = 2'h1;
    localparam logic [2:0] LIT_SUB_P = 3'h6;
    localparam logic [2:0] LIT_ADD_P = 3'h7;

    // ==========================================================================
    // File map, status layout and register port
    localparam logic [FADDR_W-1:0] TIMER_ADDR = 7'h01;
    localparam logic [FADDR_W-1:0] STATUS_ADDR = 7'h03;
    localparam logic [FADDR_W-1:0] PORT_ADDR = 7'h05;

    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_SLP = 3;
    localparam int ST_TO = 4;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;

    localparam logic [RB_ADDR_W-1:0] RB_CTRL = 2'h0;
    localparam logic [RB_ADDR_W-1:0] RB_CORE = 2'h1;
    localparam logic [RB_ADDR_W-1:0] RB_PC = 2'h2;
    localparam logic [RB_ADDR_W-1:0] RB_IR = 2'h3;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic [FADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } mcuid_file_req_t;

    typedef struct packed {
        logic [RB_ADDR_W-1:0] addr;
        logic [RB_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } mcuid_reg_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] res;
        logic c;
        logic dc;
    } mcuid_alu_t;

    // Shared by the file-register and the literal groups.
    function automatic mcuid_alu_t mcuid_alu(input logic [3:0] op, input logic [7:0] w,
                                             input logic [7:0] f, input logic c);
        mcuid_alu_t r;
        logic [8:0] s;
        logic [4:0] n;
        r = '{res: w, c: c, dc: 1'b0};
        s = {1'b0, f} - {1'b0, w};
        n = {1'b0, f[3:0]} - {1'b0, w[3:0]};
        case (op)
            OP_ADD: begin
                s = {1'b0, w} + {1'b0, f};
                n = {1'b0, w[3:0]} + {1'b0, f[3:0]};
                r = '{res: s[7:0], c: s[8], dc: n[4]};
            end
            OP_SUB: r = '{res: s[7:0], c: ~s[8], dc: ~n[4]};
            OP_CLR: r.res = 8'h00;
            OP_AND: r.res = w & f;
            OP_IOR: r.res = w | f;
            OP_XOR: r.res = w ^ f;
            OP_MOV: r.res = f;
            OP_COM: r.res = ~f;
            OP_DEC, OP_DECSKP: r.res = f - 8'h01;
            OP_INC, OP_INCSKP: r.res = f + 8'h01;
            OP_RRC: r = '{res: {c, f[7:1]}, c: f[0], dc: 1'b0};
            OP_RLC: r = '{res: {f[6:0], c}, c: f[7], dc: 1'b0};
            OP_SWAP: r.res = {f[3:0], f[7:4]};
            default: r.res = w;
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

/* src/mcuid_core.sv */
// Purpose: Fetches, decodes and executes 14-bit instruction words of an 8-bit core.
// Assumes: Every input except the asynchronous reset_n is synchronous to ref_clk; file registers answer one cycle after a read.
// Notes: Four ref_clk cycles make one instruction cycle: fetch, read, execute, advance.
//
// What this block does
// RL1: Every file-register instruction reads, modifies, then stores by opcode or destination.
// RL2: The addressed register is read even when the instruction only writes it.
// RL3: The register index is seven bits, covering locations 0x00 to 0x7F.
// RL4: Destination bit zero sends the result to the accumulator, one to the register.
// RL5: Byte OR (0100) and XOR (0110) with the accumulator change only zero.
// RL6: Rotates through carry (1101 left, 1100 right) change only carry.
// RL7: Decrement (1011) and increment (1111) skip on zero, flags untouched.
// RL8: Bit clear, set and test-if-set use two-bit opcode, position, index; no flags.
// RL9: Test-skip-if-clear takes one cycle when the bit is one, two when zero.
// RL10: The position field picks one bit of an eight-bit register.
// RL11: Return and interrupt exit pop the stack and take two cycles.
// RL12: Exit-with-literal loads the literal, returns in two cycles, low bits ignored.
// RL13: Literal OR (1000) and XOR (1010) write the accumulator, change only zero.
// RL14: Literal subtract (110x) and add (111x) change carry, nibble carry and zero.
// RL15: The watchdog kick word clears the watchdog and sets timeout and sleep flags.
// RL16: The standby word enters standby, updates both flags, takes one cycle.
// RL17: Don't-care opcode bits are ignored whatever their value.
// RL18: Reading the I/O port inside an instruction returns the pin levels.
// RL19: A file write to the timer register clears an assigned prescaler.
// RL20: Branches and true tests take two cycles, the second a no-operation.
// RL21: Data literals are eight bits, call and jump targets eleven bits.
// RL22: One instruction cycle is four clock periods; most instructions take one.
// RL23: Call and jump use prefix 10 and a selector; call pushes the return.
// RL24: Byte add and subtract change carry, nibble carry, zero; AND changes zero.
// RL25: Clear and move patterns use prefix zero; destination picks register or accumulator.
`default_nettype none

module mcuid_core (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    output logic [mcuid_pkg::PC_W-1:0] prog_addr,
    input wire logic [mcuid_pkg::INSTR_W-1:0] instr_word,
    output mcuid_pkg::mcuid_file_req_t file_req,
    input wire logic [mcuid_pkg::DATA_W-1:0] file_rdata,
    input wire logic [mcuid_pkg::DATA_W-1:0] port_pins,
    input wire logic prescaler_owned,
    input wire logic wake_req,
    output logic prescaler_clear,
    output logic wdt_clear,
    output logic standby,
    input wire mcuid_pkg::mcuid_reg_req_t reg_req,
    output logic [mcuid_pkg::RB_DATA_W-1:0] reg_rdata
);

    // ==========================================================================
    // State
    typedef struct packed {
        mcuid_pkg::mcuid_phase_t phase;
        logic [mcuid_pkg::PC_W-1:0] pc;
        logic [mcuid_pkg::INSTR_W-1:0] ir;
        logic [mcuid_pkg::DATA_W-1:0] acc;
        logic [mcuid_pkg::DATA_W-1:0] status;
        logic flush;
        logic standby;
        logic run;
        logic [mcuid_pkg::SP_W-1:0] sp;
        logic [mcuid_pkg::STACK_DEPTH-1:0][mcuid_pkg::PC_W-1:0] stack;
        mcuid_pkg::mcuid_file_req_t file;
        logic pre_clr;
        logic wdt_clr;
        logic [mcuid_pkg::RB_DATA_W-1:0] rdata;
    } mcuid_state_t;

    localparam mcuid_state_t ST_RST = '{
        phase: mcuid_pkg::ph_fetch,
        pc: mcuid_pkg::PC_RESET,
        ir: mcuid_pkg::NOP_WORD,
        acc: '0,
        status: mcuid_pkg::STATUS_RST,
        flush: 1'b0,
        standby: 1'b0,
        run: mcuid_pkg::CTRL_RUN_RST,
        sp: '0,
        stack: '0,
        file: '0,
        pre_clr: 1'b0,
        wdt_clr: 1'b0,
        rdata: '0
    };

    mcuid_state_t s;
    mcuid_state_t next_s;

    // Decides whether a word touches a file register; used only at fetch.
    function automatic logic mcuid_uses_file(input logic [mcuid_pkg::INSTR_W-1:0] w);
        logic r;
        r = 1'b0;
        if (w[13:12] == mcuid_pkg::GRP_BIT) begin
            r = 1'b1;
        end else if (w[13:12] == mcuid_pkg::GRP_BYTE) begin
            if (w[11:8] == mcuid_pkg::OP_MOVE_ACC_TO_REG) begin
                r = w[7];
            end else if (w[11:8] == mcuid_pkg::OP_CLR) begin
                r = w[7];
            end else begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // ==========================================================================
    // Execute-stage helpers
    logic [mcuid_pkg::DATA_W-1:0] fval;
    logic [mcuid_pkg::PC_W-1:0] pc1;
    logic [mcuid_pkg::PC_W-1:0] pc_nx;
    logic [3:0] fop;
    logic [3:0] lit_op;
    logic [2:0] bsel;
    logic [mcuid_pkg::DATA_W-1:0] bmask;
    mcuid_pkg::mcuid_alu_t alu_b;
    mcuid_pkg::mcuid_alu_t alu_l;
    mcuid_pkg::mcuid_alu_t r;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic wr_en;
    logic acc_en;
    logic do_pop;

    always_comb begin
        next_s = s;
        fval = file_rdata;
        pc1 = s.pc + mcuid_pkg::PC_STEP;
        pc_nx = s.pc;
        fop = s.ir[11:8];
        bsel = s.ir[9:7];
        bmask = 8'h01 << bsel; // RL10
        lit_op = mcuid_pkg::OP_MOV;
        r = '{res: s.acc, c: s.status[mcuid_pkg::ST_C], dc: s.status[mcuid_pkg::ST_DC]};
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        wr_en = 1'b0;
        acc_en = 1'b0;
        do_pop = 1'b0;
        next_s.file.rd = 1'b0;
        next_s.file.wr = 1'b0;
        next_s.pre_clr = 1'b0;
        next_s.wdt_clr = 1'b0;

        // Port pins stand in for the latch; status is held here, not in the file.
        if (s.file.addr == mcuid_pkg::PORT_ADDR) begin
            fval = port_pins; // RL18
        end else if (s.file.addr == mcuid_pkg::STATUS_ADDR) begin
            fval = s.status;
        end

        // Literal group opcode, with its don't-care bits left unread.
        if (s.ir[11:8] == mcuid_pkg::LIT_OR) begin
            lit_op = mcuid_pkg::OP_IOR; // RL13
        end else if (s.ir[11:8] == mcuid_pkg::LIT_AND) begin
            lit_op = mcuid_pkg::OP_AND;
        end else if (s.ir[11:8] == mcuid_pkg::LIT_XOR) begin
            lit_op = mcuid_pkg::OP_XOR; // RL13
        end else if (s.ir[11:9] == mcuid_pkg::LIT_SUB_P) begin
            lit_op = mcuid_pkg::OP_SUB; // RL14 RL17
        end else if (s.ir[11:9] == mcuid_pkg::LIT_ADD_P) begin
            lit_op = mcuid_pkg::OP_ADD; // RL14 RL17
        end
        alu_b = mcuid_pkg::mcuid_alu(fop, s.acc, fval, s.status[mcuid_pkg::ST_C]);
        alu_l = mcuid_pkg::mcuid_alu(lit_op, s.acc, s.ir[7:0], s.status[mcuid_pkg::ST_C]);

        // ======================================================================
        // Register port
        if (reg_req.wr && reg_req.addr == mcuid_pkg::RB_CTRL) begin
            next_s.run = reg_req.wdata[mcuid_pkg::CTRL_RUN_BIT];
        end
        next_s.rdata = '0;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                mcuid_pkg::RB_CTRL: next_s.rdata = {15'h0000, s.run};
                mcuid_pkg::RB_CORE: next_s.rdata = {s.status, s.acc};
                mcuid_pkg::RB_PC: next_s.rdata = {3'h0, s.pc};
                mcuid_pkg::RB_IR: next_s.rdata = {2'h0, s.ir};
            endcase
        end

        // ======================================================================
        // Instruction cycle
        if (s.run) begin
            unique case (s.phase) // RL22
                mcuid_pkg::ph_fetch: begin
                    if (s.standby) begin
                        next_s.standby = ~wake_req;
                    end else begin
                        next_s.phase = mcuid_pkg::ph_read;
                        next_s.ir = s.flush ? mcuid_pkg::NOP_WORD : instr_word; // RL20
                        if (!s.flush && mcuid_uses_file(instr_word)) begin
                            next_s.file.addr = instr_word[6:0]; // RL3
                            next_s.file.rd = 1'b1; // RL2
                        end
                    end
                end
                mcuid_pkg::ph_read: begin
                    next_s.phase = mcuid_pkg::ph_exec;
                end
                mcuid_pkg::ph_exec: begin
                    next_s.phase = mcuid_pkg::ph_adv;
                    next_s.flush = 1'b0;
                    pc_nx = s.flush ? s.pc : pc1;
                    if (!s.flush) begin
                        unique case (s.ir[13:12])
                            mcuid_pkg::GRP_BYTE: begin
                                if (fop == mcuid_pkg::OP_MOVE_ACC_TO_REG && !s.ir[7]) begin
                                    // Control words; unlisted codes run as no-operation.
                                    if (s.ir[7:0] == mcuid_pkg::CTL_RETURN) begin
                                        do_pop = 1'b1; // RL11
                                    end else if (s.ir[7:0] == mcuid_pkg::CTL_IEXIT) begin
                                        do_pop = 1'b1; // RL11
                                    end else if (s.ir[7:0] == mcuid_pkg::CTL_KICK) begin
                                        next_s.wdt_clr = 1'b1; // RL15
                                        next_s.status[mcuid_pkg::ST_TO] = 1'b1; // RL15
                                        next_s.status[mcuid_pkg::ST_SLP] = 1'b1; // RL15
                                    end else if (s.ir[7:0] == mcuid_pkg::CTL_STANDBY) begin
                                        next_s.wdt_clr = 1'b1;
                                        next_s.standby = 1'b1; // RL16
                                        next_s.status[mcuid_pkg::ST_TO] = 1'b1; // RL16
                                        next_s.status[mcuid_pkg::ST_SLP] = 1'b0; // RL16
                                    end
                                end else begin
                                    r = alu_b; // RL1
                                    wr_en = s.ir[7]; // RL4 RL25
                                    acc_en = ~s.ir[7]; // RL4 RL25
                                    unique case (fop)
                                        mcuid_pkg::OP_ADD, mcuid_pkg::OP_SUB: begin
                                            upd_z = 1'b1; // RL24
                                            upd_c = 1'b1; // RL24
                                            upd_dc = 1'b1; // RL24
                                        end
                                        mcuid_pkg::OP_RLC, mcuid_pkg::OP_RRC: begin
                                            upd_c = 1'b1; // RL6
                                        end
                                        mcuid_pkg::OP_DECSKP, mcuid_pkg::OP_INCSKP: begin
                                            if (alu_b.res == 8'h00) begin
                                                pc_nx = s.pc + mcuid_pkg::PC_SKIP; // RL7
                                                next_s.flush = 1'b1; // RL7 RL20
                                            end
                                        end
                                        mcuid_pkg::OP_MOVE_ACC_TO_REG, mcuid_pkg::OP_SWAP: begin
                                            upd_z = 1'b0;
                                        end
                                        default: begin
                                            upd_z = 1'b1; // RL5 RL24
                                        end
                                    endcase
                                end
                            end
                            mcuid_pkg::GRP_BIT: begin
                                r.res = fval;
                                unique case (s.ir[11:10]) // RL8
                                    mcuid_pkg::BIT_CLR: begin
                                        r.res = fval & ~bmask; // RL8
                                        wr_en = 1'b1;
                                    end
                                    mcuid_pkg::BIT_SET: begin
                                        r.res = fval | bmask; // RL8
                                        wr_en = 1'b1;
                                    end
                                    mcuid_pkg::BIT_TSC: begin
                                        if (!fval[bsel]) begin
                                            pc_nx = s.pc + mcuid_pkg::PC_SKIP; // RL9
                                            next_s.flush = 1'b1; // RL9
                                        end
                                    end
                                    mcuid_pkg::BIT_TSS: begin
                                        if (fval[bsel]) begin
                                            pc_nx = s.pc + mcuid_pkg::PC_SKIP; // RL8
                                            next_s.flush = 1'b1; // RL20
                                        end
                                    end
                                endcase
                            end
                            mcuid_pkg::GRP_FLOW: begin
                                if (!s.ir[11]) begin
                                    next_s.stack[s.sp] = pc1; // RL23
                                    next_s.sp = s.sp + 3'h1;
                                end
                                pc_nx = {s.pc[12:11], s.ir[10:0]}; // RL21 RL23
                                next_s.flush = 1'b1; // RL20
                            end
                            mcuid_pkg::GRP_LIT: begin
                                r = alu_l;
                                acc_en = 1'b1;
                                if (s.ir[11:10] == mcuid_pkg::LIT_MOV_P) begin
                                    r.res = s.ir[7:0]; // RL21
                                end else if (s.ir[11:10] == mcuid_pkg::LIT_RET_P) begin
                                    r.res = s.ir[7:0]; // RL12
                                    do_pop = 1'b1; // RL12
                                end else begin
                                    upd_z = 1'b1; // RL13
                                    upd_c = (lit_op == mcuid_pkg::OP_ADD) ||
                                            (lit_op == mcuid_pkg::OP_SUB); // RL14
                                    upd_dc = upd_c; // RL14
                                end
                            end
                        endcase
                    end

                    // Results and flags.
                    if (do_pop) begin
                        next_s.sp = s.sp - 3'h1;
                        pc_nx = s.stack[s.sp - 3'h1]; // RL11
                        next_s.flush = 1'b1; // RL20
                    end
                    if (acc_en) begin
                        next_s.acc = r.res; // RL4
                    end
                    if (upd_z) begin
                        next_s.status[mcuid_pkg::ST_Z] = (r.res == 8'h00);
                    end
                    if (upd_c) begin
                        next_s.status[mcuid_pkg::ST_C] = r.c;
                    end
                    if (upd_dc) begin
                        next_s.status[mcuid_pkg::ST_DC] = r.dc;
                    end
                    if (wr_en) begin
                        next_s.file.wr = 1'b1; // RL1
                        next_s.file.wdata = r.res;
                        // A direct store to status overrides the arithmetic flags.
                        if (s.file.addr == mcuid_pkg::STATUS_ADDR) begin
                            next_s.status[2:0] = r.res[2:0];
                        end
                        if (s.file.addr == mcuid_pkg::TIMER_ADDR && prescaler_owned) begin
                            next_s.pre_clr = 1'b1; // RL19
                        end
                    end
                    next_s.pc = pc_nx;
                end
                mcuid_pkg::ph_adv: begin
                    next_s.phase = mcuid_pkg::ph_fetch;
                end
            endcase
        end
    end

    // ==========================================================================
    // State register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= ST_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign prog_addr = s.pc;
    assign file_req = s.file;
    assign prescaler_clear = s.pre_clr;
    assign wdt_clear = s.wdt_clr;
    assign standby = s.standby;
    assign reg_rdata = s.rdata;

endmodule // mcuid_core

`default_nettype wire

/* verification/mcuid_core_props.sv */
// Purpose: Timing checks on the file, program and register ports.
// Assumes: clk_en held high.
// Notes: Bound to the core.
`default_nettype none
module mcuid_core_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [12:0] prog_addr,
    input wire mcuid_pkg::mcuid_file_req_t file_req,
    input wire logic prescaler_owned,
    input wire logic prescaler_clear,
    input wire logic wdt_clear,
    input wire logic standby,
    input wire mcuid_pkg::mcuid_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    rd_before_wr_a: assert property (file_req.wr |-> $past(file_req.rd, 2))
        else $error("write without read");
    same_addr_a: assert property (file_req.wr |-> file_req.addr == $past(file_req.addr, 2))
        else $error("write address moved");
    wr_pulse_a: assert property (file_req.wr |=> !file_req.wr)
        else $error("long write");
    rd_gap_a: assert property (file_req.rd |=> !file_req.rd && $stable(prog_addr))
        else $error("read phase wrong");
    pre_clear_a: assert property (prescaler_clear |-> file_req.wr &&
        file_req.addr == 7'h01 && prescaler_owned) else $error("stray prescaler clear");
    kick_pulse_a: assert property (wdt_clear |=> !wdt_clear)
        else $error("long watchdog clear");
    standby_quiet_a: assert property (standby |-> !file_req.rd && !file_req.wr)
        else $error("file access in standby");
    rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    cover property (prescaler_clear);
    cover property ($rose(standby));
    cover property (reg_req.rd);
endmodule // mcuid_core_props
bind mcuid_core mcuid_core_props u_props (.ref_clk, .reset_n, .prog_addr, .file_req,
    .prescaler_owned, .prescaler_clear, .wdt_clear, .standby, .reg_req, .reg_rdata);
`default_nettype wire

/* verification/mcuid_mem_model.sv */
// Purpose: Program memory and file registers facing the core.
// Assumes: Read data due one cycle after the read strobe.
// Notes: Unanswered read data flips every cycle, so a stale value never looks valid.
`default_nettype none
module mcuid_mem_model (
    input wire logic ref_clk,
    input wire logic [12:0] prog_addr,
    output logic [13:0] instr_word,
    input wire mcuid_pkg::mcuid_file_req_t file_req,
    output logic [7:0] file_rdata
);
    logic [13:0] rom [0:63];
    logic [7:0] regs [0:127];
    initial file_rdata = 8'h5A;
    assign instr_word = rom[prog_addr[5:0]];
    always @(posedge ref_clk) begin
        file_rdata <= file_req.rd ? regs[file_req.addr] : ~file_rdata;
        if (file_req.wr) begin
            regs[file_req.addr] <= file_req.wdata;
        end
    end
endmodule // mcuid_mem_model
`default_nettype wire

/* verification/mcuid_core_tb.sv */
// Purpose: Runs a short program through the core and checks the results.
// Assumes: clk_en high, prescaler owned by the timer.
// Notes: A missed skip or jump corrupts the accumulator seen at the end.
`default_nettype none
module mcuid_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wake_req = 1'b0;
    logic [12:0] prog_addr;
    logic [13:0] instr_word;
    logic [7:0] file_rdata;
    logic prescaler_clear, wdt_clear, standby;
    logic [15:0] reg_rdata;
    mcuid_pkg::mcuid_file_req_t file_req;
    mcuid_pkg::mcuid_reg_req_t reg_req = '0;
    int n_mismatch = 0, checked = 0, n_kick = 0, n_pre = 0;
    always #2 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        n_kick += int'(wdt_clear === 1'b1);
        n_pre += int'(prescaler_clear === 1'b1);
    end
    mcuid_core u_mcuid_core (.ref_clk, .reset_n, .clk_en(1'b1), .prog_addr, .instr_word,
        .file_req, .file_rdata, .port_pins(8'hA5), .prescaler_owned(1'b1), .wake_req,
        .prescaler_clear, .wdt_clear, .standby, .reg_req, .reg_rdata);
    mcuid_mem_model u_mcuid_mem_model (.ref_clk, .prog_addr, .instr_word, .file_req,
        .file_rdata);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic reg_access(input logic [1:0] a, input logic wr, output logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, wdata: 16'hFFFF, wr: wr, rd: !wr};
        @(posedge ref_clk);
        reg_req <= '0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic program_flow();
        for (int i = 0; i < 400 && standby !== 1'b1; i++) @(posedge ref_clk);
        check(16'(standby), 16'h0001);
        check(16'(u_mcuid_mem_model.regs[7'h20]), 16'h0011);
        check(16'(u_mcuid_mem_model.regs[7'h21]), 16'h0000);
        check(16'(u_mcuid_mem_model.regs[7'h22]), 16'h0080);
        check(16'(u_mcuid_mem_model.regs[7'h05]), 16'h00BF);
        check(16'(u_mcuid_mem_model.regs[7'h01]), 16'h001B);
        check(16'(n_pre), 16'h0001);
        check(16'(n_kick), 16'h0002);
    endtask
    task automatic register_port();
        logic [15:0] d;
        reg_access(2'h1, 1'b1, d);
        reg_access(2'h1, 1'b0, d);
        check(d, 16'h121B);
        reg_access(2'h0, 1'b0, d);
        check(d, 16'h0001);
    endtask
    task automatic wake_flow();
        logic [15:0] d;
        @(posedge ref_clk);
        wake_req <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check(16'(standby), 16'h0000);
        reg_access(2'h2, 1'b0, d);
        check(d, 16'h000F);
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        static logic [13:0] p [16] = '{14'h3305, 14'h07A0, 14'h0620, 14'h0BA1, 14'h38FF, 14'h19A2,
            14'h38FF, 14'h3A0F, 14'h17A2, 14'h0485, 14'h0081, 14'h280D, 14'h38FF,
            14'h0064, 14'h0063, 14'h280F};
        for (int i = 0; i < 16; i++) u_mcuid_mem_model.rom[i] = p[i];
        u_mcuid_mem_model.regs[7'h20] = 8'h0C;
        u_mcuid_mem_model.regs[7'h21] = 8'h01;
        u_mcuid_mem_model.regs[7'h22] = 8'h00;
        u_mcuid_mem_model.regs[7'h05] = 8'h00;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        program_flow();
        register_port();
        wake_flow();
        final_report();
    end
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule // mcuid_core_tb
`default_nettype wire
